// ---- rtl/spm_mode_ctrl.v ----
// mode control for an asynchronous serial port: mode register, pin muxing, wake and rate detect
`timescale 1ns/100ps
`default_nettype none
`include "spm_map.vh"
module spm_mode_ctrl #(
  parameter CW = 16
) (
  // clock and reset
  input wire clock,
  input wire srst,
  // register port
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  // device power state
  input wire device_idle,
  input wire device_sleep,
  // core serial datapath
  input wire core_tx,
  input wire core_rts,
  output wire core_rx,
  output wire core_cts,
  output wire core_run,
  input wire core_bclk,
  // port latch values for pins not owned by the port
  input wire [3:0] latch_out,
  input wire [3:0] latch_oe,
  // pins: 0 transmit, 1 request, 2 baud clock, 3 clear to send
  input wire receive_pin,
  input wire clear_to_send_pin,
  output reg transmit_pin,
  output reg transmit_pin_oe,
  output reg request_to_send_pin,
  output reg request_to_send_pin_oe,
  output reg bclk_pin,
  output reg bclk_pin_oe,
  output reg clear_to_send_pin_out,
  output reg clear_to_send_pin_oe,
  // events and mode outputs
  output reg wake_irq,
  output wire request_simplex,
  output wire infrared_active,
  output reg [CW-1:0] rate_period
);
  // register state; the mode register and the local control register are the software-visible configuration
  reg [15:0] serial_port_mode; // software mode register
  reg [1:0] power_ctrl; // idle and sleep emulation bits
  reg rx_q; // previous receive level
  reg wake_armed; // falling edge seen, waiting for rising edge
  // decoded mode fields and internal line taps
  wire enable;
  wire [1:0] pin_set_select;
  wire loopback_select;
  wire meas_done;
  wire rx_line;
  wire rx_dec;
  wire tx_enc;
  wire idle_now;
  wire sleep_now;
  // result of the rate meter, captured on its done pulse
  wire [CW-1:0] rate_period_w;
  // field decode straight off the mode register
  assign enable = serial_port_mode[`SPM_BIT_ENABLE];
  assign pin_set_select = serial_port_mode[`SPM_BIT_PINSEL_HI:`SPM_BIT_PINSEL_LO];
  assign loopback_select = serial_port_mode[`SPM_BIT_LOOPBACK];
  // power state may come from the device pins or from the emulation bits
  assign idle_now = device_idle | power_ctrl[`SPM_CTRL_BIT_IDLE];
  assign sleep_now = device_sleep | power_ctrl[`SPM_CTRL_BIT_SLEEP];
  // the port halts in idle only when idle stop is set
  assign core_run = enable & ~(idle_now & serial_port_mode[`SPM_BIT_IDLE_STOP]);
  // infrared needs the sixteen-times baud divider; otherwise bypassed
  assign infrared_active = serial_port_mode[`SPM_BIT_IR_ENABLE]
    & ~serial_port_mode[`SPM_BIT_HIGH_SPEED];
  // request pin mode is passed on; the core shapes the pin itself
  assign request_simplex = serial_port_mode[`SPM_BIT_RTS_MODE];
  // loopback and infrared both sit between the pins and the core
  // infrared: idle low, pulse on zero bits; decoder inverts back
  assign tx_enc = infrared_active ? ~core_tx : core_tx;
  // loopback feeds transmit back internally, ignoring the pin
  assign rx_line = loopback_select ? tx_enc : receive_pin;
  assign rx_dec = infrared_active ? ~rx_line : rx_line;
  // optional receive polarity inversion applies after the decoder
  assign core_rx = rx_dec ^ serial_port_mode[`SPM_BIT_RX_INVERT];
  // clear to send only used in the rts/cts pin set; held asserted low otherwise
  assign core_cts = (pin_set_select == `SPM_PINSEL_RTSCTS) ? clear_to_send_pin : 1'b0;
  // pin ownership: unselected pins stay on their port latches
  // pin outputs are combinational so ownership changes take effect at once
  always @* begin
    // defaults first, so no path through the mux infers a latch
    // transmit pin
    transmit_pin = latch_out[0];
    transmit_pin_oe = latch_oe[0];
    // request to send pin
    request_to_send_pin = latch_out[1];
    request_to_send_pin_oe = latch_oe[1];
    // baud clock pin
    bclk_pin = latch_out[2];
    bclk_pin_oe = latch_oe[2];
    // clear to send pin
    clear_to_send_pin_out = latch_out[3];
    clear_to_send_pin_oe = latch_oe[3];
    if (enable) begin
      // in loopback the transmit pin idles high instead of carrying data
      transmit_pin = loopback_select ? 1'b1 : tx_enc;
      transmit_pin_oe = 1'b1;
      case (pin_set_select)
        `SPM_PINSEL_RTS: begin
          // request pin owned; clear to send left on its latch
          request_to_send_pin = core_rts;
          request_to_send_pin_oe = 1'b1;
        end
        `SPM_PINSEL_RTSCTS: begin
          // both handshake pins owned; clear to send becomes an input
          request_to_send_pin = core_rts;
          request_to_send_pin_oe = 1'b1;
          clear_to_send_pin_oe = 1'b0;
        end
        `SPM_PINSEL_BCLK: begin
          // baud clock driven out; clear to send stays on its latch
          bclk_pin = core_bclk;
          bclk_pin_oe = 1'b1;
        end
        default: begin
          // only transmit and receive are owned
          transmit_pin_oe = 1'b1;
        end
      endcase
    end
  end
  // rate meter watches the decoded line, so infrared framing is stripped first
  // a measurement still waiting for its start edge is abandoned when the port is disabled; one already counting runs on
  spm_rate_meter #(
    .CW(CW)
  ) u_meter (
    .clock(clock),
    .srst(srst),
    .arm(serial_port_mode[`SPM_BIT_AUTO_RATE] & enable),
    .rx(rx_dec),
    .done(meas_done),
    .period(rate_period_w)
  );
  // register writes and hardware clears of the self-clearing bits
  always @(posedge clock) begin
    if (srst) begin
      // all writable bits clear at reset
      serial_port_mode <= `SPM_MODE_RESET;
      power_ctrl <= 2'h0;
      // the edge detector starts at the idle level so reset makes no false edge
      rx_q <= 1'b1;
      wake_armed <= 1'b0;
      wake_irq <= 1'b0;
      rate_period <= {CW{1'b0}};
    end else begin
      rx_q <= rx_line;
      wake_irq <= 1'b0;
      // software writes go through the mask; reserved bits stay zero
      if (wr && addr == `SPM_MODE_ADDR) begin
        serial_port_mode <= wdata & `SPM_MODE_WMASK;
      end
      // emulation bits let software exercise idle and sleep behaviour
      // the control register is local to this block, not a device register
      if (wr && addr == `SPM_CTRL_ADDR) begin
        power_ctrl <= wdata[1:0];
      end
      // wake: interrupt on falling edge while asleep
      // limitation: the edge is taken on the undecoded line, ahead of infrared decoding
      // the armed flag holds the falling edge until the line returns high
      if (serial_port_mode[`SPM_BIT_WAKE] && sleep_now && rx_q && !rx_line) begin
        wake_irq <= 1'b1;
        wake_armed <= 1'b1;
      end
      // bit drops on the following rising edge; overrides a same-cycle write
      if (wake_armed && !rx_q && rx_line) begin
        serial_port_mode[`SPM_BIT_WAKE] <= 1'b0;
        wake_armed <= 1'b0;
      end
      // measurement result, then detect bit clears itself
      // the meter's done lasts one cycle, so the clear is applied exactly once
      if (meas_done) begin
        rate_period <= rate_period_w;
        serial_port_mode[`SPM_BIT_AUTO_RATE] <= 1'b0;
      end
    end
  end
  // read data one cycle after the strobe; unmapped reads as zero
  always @(posedge clock) begin
    if (srst) begin
      // read data idles at zero
      rdata <= 16'h0000;
    end else if (rd) begin
      // decode the register index; status packs wake armed, run and infrared
      // an unmapped index returns zero
      case (addr)
        `SPM_MODE_ADDR: rdata <= serial_port_mode;
        `SPM_CTRL_ADDR: rdata <= {14'h0000, power_ctrl};
        `SPM_STAT_ADDR: rdata <= {13'h0000, wake_armed, core_run, infrared_active};
        `SPM_RATE_ADDR: rdata <= rate_period[15:0];
        default: rdata <= 16'h0000;
      endcase
    end else begin
      // no strobe, no data: stale reads never linger on the bus
      rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/spm_map.vh ----
// register offsets, field positions, reset values and timing counts of the serial port mode block
`ifndef SPM_MAP_VH
`define SPM_MAP_VH
`define SPM_MODE_ADDR 4'h0
`define SPM_CTRL_ADDR 4'h1
`define SPM_STAT_ADDR 4'h2
`define SPM_RATE_ADDR 4'h3
`define SPM_MODE_RESET 16'h0000
`define SPM_MODE_WMASK 16'hBBFF
`define SPM_BIT_ENABLE 15
`define SPM_BIT_IDLE_STOP 13
`define SPM_BIT_IR_ENABLE 12
`define SPM_BIT_RTS_MODE 11
`define SPM_BIT_PINSEL_HI 9
`define SPM_BIT_PINSEL_LO 8
`define SPM_BIT_WAKE 7
`define SPM_BIT_LOOPBACK 6
`define SPM_BIT_AUTO_RATE 5
`define SPM_BIT_RX_INVERT 4
`define SPM_BIT_HIGH_SPEED 3
`define SPM_CTRL_BIT_IDLE 0
`define SPM_CTRL_BIT_SLEEP 1
`define SPM_PINSEL_TXRX 2'h0
`define SPM_PINSEL_RTS 2'h1
`define SPM_PINSEL_RTSCTS 2'h2
`define SPM_PINSEL_BCLK 2'h3
`define SPM_SYNC_EDGES 4'h5
`endif

// ---- rtl/spm_rate_meter.v ----
// measures the bit period from a sync character on the receive line
`timescale 1ns/100ps
`default_nettype none
`include "spm_map.vh"
module spm_rate_meter #(
  parameter CW = 16
) (
  // clock and reset
  input wire clock,
  input wire srst,
  // control
  input wire arm,
  input wire rx,
  // result
  output reg done,
  output reg [CW-1:0] period
);
  // one-hot states
  localparam S_IDLE = 3'b001;
  localparam S_WAIT = 3'b010;
  localparam S_MEAS = 3'b100;
  reg [2:0] state;
  reg rx_q; // previous line level for edge detect
  reg [3:0] edges; // falling edges seen within the sync field
  reg [CW-1:0] count; // cycles since the start bit edge
  wire fall;
  assign fall = rx_q & ~rx;
  // a 55h field gives five falling edges spanning eight bit times
  always @(posedge clock) begin
    if (srst) begin
      state <= S_IDLE;
      rx_q <= 1'b1;
      edges <= 4'h0;
      count <= {CW{1'b0}};
      done <= 1'b0;
      period <= {CW{1'b0}};
    end else begin
      rx_q <= rx;
      done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (arm) begin
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          // the first falling edge is the start bit of the sync field
          if (!arm) begin
            state <= S_IDLE;
          end else if (fall) begin
            state <= S_MEAS;
            edges <= 4'h1;
            count <= {CW{1'b0}};
          end
        end
        S_MEAS: begin
          count <= count + 1'b1;
          if (fall) begin
            edges <= edges + 4'h1;
            if (edges + 4'h1 == `SPM_SYNC_EDGES) begin
              // eight bit times elapsed: divide by eight
              period <= (count + 1'b1) >> 3;
              done <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/spm_remote.sv ----
// remote serial transmitter model on the receive and clear-to-send pins
`timescale 1ns/100ps
`default_nettype none
module spm_remote #(parameter BP = 16) (
  // clock and driven pins
  input wire clock,
  output logic rx,
  output logic cts_n
);
  // the line rests at mark level and the remote starts ready to take data
  initial begin
    rx = 1'h1;
    cts_n = 1'h0;
  end
  // start bit, eight data bits lsb first, stop bit; each bit held BP cycles
  task send(input [7:0] b);
    logic [9:0] f;
    integer i;
    f = {1'h1, b, 1'h0};
    for (i = 0; i < 10; i++) begin
      @(posedge clock);
      rx <= f[i];
      repeat (BP - 1) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/spm_mode_ctrl_chk.sv ----
// assertion checker for the serial port mode block
`timescale 1ns/100ps
`default_nettype none
`include "spm_map.vh"
module spm_chk (
  // clock, reset, register writes, device idle and core inputs
  input wire clock, input wire srst, input wire [3:0] addr, input wire [15:0] wdata,
  input wire wr, input wire device_idle, input wire core_tx, input wire core_bclk,
  // latches, pins and mode outputs
  input wire [3:0] latch_out, input wire [3:0] latch_oe, input wire transmit_pin,
  input wire transmit_pin_oe, input wire request_to_send_pin_oe, input wire bclk_pin,
  input wire bclk_pin_oe, input wire clear_to_send_pin_oe, input wire core_rx,
  input wire core_run, input wire wake_irq, input wire request_simplex,
  input wire infrared_active
);
  reg [15:0] m; // shadow of written mode bits; self-clearing bits may lag, so only the wake bit is used, through $past
  // shadow follows software writes only
  always @(posedge clock) begin
    if (srst) m <= 16'h0000;
    else if (wr && addr == `SPM_MODE_ADDR) m <= wdata & `SPM_MODE_WMASK;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  off_latch_a: assert property (!m[15] |->
    transmit_pin_oe == latch_oe[0] && transmit_pin == latch_out[0]) else $error("tx not latch");
  pins_txrx_a: assert property (m[15] && m[9:8] == 2'h0 |->
    request_to_send_pin_oe == latch_oe[1] && clear_to_send_pin_oe == latch_oe[3])
    else $error("pin set 0");
  pins_bclk_a: assert property (m[15] && m[9:8] == 2'h3 |->
    bclk_pin_oe && bclk_pin == core_bclk) else $error("pin set 3");
  req_mode_a: assert property (m[15] |-> request_simplex == m[11])
    else $error("request mode");
  ir_rate_a: assert property (m[3] |-> !infrared_active) else $error("ir fast");
  ir_on_a: assert property (m[15] && m[12] && !m[3] |-> infrared_active)
    else $error("ir off");
  loop_path_a: assert property (m[15] && m[6] && !m[12] && !m[4] |->
    transmit_pin && core_rx == core_tx) else $error("loopback");
  wake_pulse_a: assert property (wake_irq |-> $past(m[7]) ##1 !wake_irq)
    else $error("wake pulse");
  idle_stop_a: assert property (m[15] && m[13] && device_idle |-> !core_run)
    else $error("idle run");
  cover property (wake_irq);
  cover property (m[15] && m[6]);
  cover property (m[15] && m[9:8] == 2'h3);
endmodule
bind spm_mode_ctrl spm_chk chk (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
  .wr(wr), .device_idle(device_idle), .core_tx(core_tx), .core_bclk(core_bclk),
  .latch_out(latch_out), .latch_oe(latch_oe), .transmit_pin(transmit_pin),
  .transmit_pin_oe(transmit_pin_oe), .request_to_send_pin_oe(request_to_send_pin_oe),
  .bclk_pin(bclk_pin), .bclk_pin_oe(bclk_pin_oe), .clear_to_send_pin_oe(clear_to_send_pin_oe),
  .core_rx(core_rx), .core_run(core_run), .wake_irq(wake_irq),
  .request_simplex(request_simplex), .infrared_active(infrared_active));
`default_nettype wire

// ---- tb/tb.sv ----
// testbench for the serial port mode block
`timescale 1ns/100ps
`default_nettype none
`include "spm_map.vh"
module tb;
  localparam BP = 16; // bit period of the remote in clock cycles
  logic clock = 1'h0, srst = 1'h1, wr = 1'h0, rd = 1'h0, device_idle = 1'h0;
  logic device_sleep = 1'h0, core_tx = 1'h1, core_rts = 1'h0, core_bclk = 1'h0;
  logic [3:0] addr = 4'h0, latch_out = 4'hA, latch_oe = 4'h0;
  logic [15:0] wdata = 16'h0000;
  wire [15:0] rdata, rate_period;
  wire rx, cts, core_rx, core_run, wake_irq, request_simplex, infrared_active;
  wire transmit_pin, transmit_pin_oe, request_to_send_pin_oe, bclk_pin_oe;
  wire request_to_send_pin, core_cts;
  integer mismatches = 0, tests_run = 0, cyc = 0, wakes = 0, p;
  spm_mode_ctrl uut (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .device_idle(device_idle), .device_sleep(device_sleep),
    .core_tx(core_tx), .core_rts(core_rts), .core_rx(core_rx), .core_cts(core_cts),
    .core_run(core_run),
    .core_bclk(core_bclk), .latch_out(latch_out), .latch_oe(latch_oe), .receive_pin(rx),
    .clear_to_send_pin(cts), .transmit_pin(transmit_pin), .transmit_pin_oe(transmit_pin_oe),
    .request_to_send_pin(request_to_send_pin),
    .request_to_send_pin_oe(request_to_send_pin_oe), .bclk_pin(),
    .bclk_pin_oe(bclk_pin_oe), .clear_to_send_pin_out(), .clear_to_send_pin_oe(),
    .wake_irq(wake_irq), .request_simplex(request_simplex),
    .infrared_active(infrared_active), .rate_period(rate_period));
  spm_remote #(.BP(BP)) rem (.clock(clock), .rx(rx), .cts_n(cts));
  always #5 clock = ~clock;
  // cycle ceiling cuts a hang short; wake pulses are counted as they stand
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (wake_irq === 1'h1) wakes <= wakes + 1;
    if (cyc == 5000) begin
      mismatches++;
      stop_test;
    end
  end
  task chk(input [15:0] s, input [15:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one-cycle write; returns just after the edge that took it
  task wreg(input [3:0] a, input [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
    #1;
  endtask
  // one-cycle read; data stands only in the following cycle
  task rreg(input [3:0] a, input [15:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    #1;
    chk(rdata, e);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'h0;
    rreg(`SPM_MODE_ADDR, 16'h0000);
    wreg(`SPM_MODE_ADDR, 16'hFFFF);
    rreg(`SPM_MODE_ADDR, 16'hBBFF);
    wreg(4'hF, 16'hFFFF);
    rreg(4'hF, 16'h0000);
    // every pin set: tx always owned, rts for 01 and 10, baud clock for 11, cts only for 10
    // the remote holds its clear-to-send line high so the routing shows on core_cts
    rem.cts_n <= 1'h1;
    for (p = 0; p < 4; p++) begin
      wreg(`SPM_MODE_ADDR, 16'h8000 | 16'(p << 8));
      chk(16'({transmit_pin_oe, request_to_send_pin_oe, bclk_pin_oe, request_to_send_pin,
          core_cts}), 16'(16 + 8 * (p == 1 || p == 2) + 4 * (p == 3) + 2 * (p == 0 || p == 3)
          + (p == 2)));
    end
    rem.cts_n <= 1'h0;
    wreg(`SPM_MODE_ADDR, 16'h0000);
    chk(16'(transmit_pin_oe), 16'h0000);
    wreg(`SPM_MODE_ADDR, 16'h8800);
    chk(16'(request_simplex), 16'h0001);
    // idle entry with and without the stop bit
    for (p = 0; p < 2; p++) begin
      wreg(`SPM_MODE_ADDR, 16'h8000 | 16'(p << 13));
      @(posedge clock) device_idle <= 1'h1;
      #1 chk(16'(core_run), 16'(p == 0));
      @(posedge clock) device_idle <= 1'h0;
    end
    // the control register's idle bit stands in for the device pin; status shows the halt
    wreg(`SPM_CTRL_ADDR, 16'h0001);
    chk(16'(core_run), 16'h0000);
    rreg(`SPM_CTRL_ADDR, 16'h0001);
    rreg(`SPM_STAT_ADDR, 16'h0000);
    wreg(`SPM_CTRL_ADDR, 16'h0000);
    rreg(`SPM_STAT_ADDR, 16'h0002);
    wreg(`SPM_MODE_ADDR, 16'h9000);
    chk(16'(infrared_active), 16'h0001);
    wreg(`SPM_MODE_ADDR, 16'h9008);
    chk(16'(infrared_active), 16'h0000);
    wreg(`SPM_MODE_ADDR, 16'h8040);
    for (p = 0; p < 2; p++) begin
      @(posedge clock) core_tx <= p[0];
      #1 chk(16'({transmit_pin, core_rx}), 16'(2 + p));
    end
    wreg(`SPM_MODE_ADDR, 16'h8020);
    rem.send(8'h55);
    rreg(`SPM_MODE_ADDR, 16'h8000);
    rreg(`SPM_RATE_ADDR, 16'(BP));
    @(posedge clock) device_sleep <= 1'h1;
    wreg(`SPM_MODE_ADDR, 16'h8080);
    rem.send(8'hF0);
    // the bit is gone now, so a second start edge must not raise another pulse
    rem.send(8'hF0);
    rreg(`SPM_MODE_ADDR, 16'h8000);
    chk(16'(wakes), 16'h0001);
    stop_test;
  end
endmodule
`default_nettype wire
